// ==== logic/ptq_defines.svh ====
// How it works
// R01: above threshold is high, below is low
// R02: per channel high, low, ignore, rise, fall
// R03: pattern true when all participants meet criteria
// R04: entered condition fires on false-to-true
// R05: exited condition fires on true-to-false
// R06: longer-than fires past programmed duration
// R07: longer-than fires at end or timeout
// R08: shorter-than fires on short pattern end
// R09: window fires on end inside min/max
// R10: window min and max range limits
// R11: analog 1..4 channels, digital 0..15
// R12: active only in advanced pattern mode
// R13: retrigger delay and noise reject conditioning
// R14: configuration and criteria read back
// R15: one threshold per channel, shared
// R16: duration counter restarts on pattern start
`ifndef PTQ_DEFINES_SVH
`define PTQ_DEFINES_SVH

// ----------------------------------------------------------------
// clock and counter widths
// ----------------------------------------------------------------
`define PTQ_CLK_PS          64'd10000
`define PTQ_DUR_W           30

// ----------------------------------------------------------------
// programmable time limits, in picoseconds
// ----------------------------------------------------------------
`define PTQ_TIME_MIN_PS     64'd1500
`define PTQ_TIME_MAX_PS     64'd10000000000000
`define PTQ_WMIN_MIN_PS     64'd10000
`define PTQ_WMIN_MAX_PS     64'd9999999900000
`define PTQ_WMAX_MIN_PS     64'd15000
`define PTQ_WMAX_MAX_PS     64'd10000000000000

// ----------------------------------------------------------------
// limits in cycles: least rounds up, longest rounds down
// ----------------------------------------------------------------
`define PTQ_CEIL_CYC(ps)    (((ps) + `PTQ_CLK_PS - 64'd1) / `PTQ_CLK_PS)
`define PTQ_FLOOR_CYC(ps)   ((ps) / `PTQ_CLK_PS)
`define PTQ_TIME_MIN_CYC    `PTQ_CEIL_CYC(`PTQ_TIME_MIN_PS)
`define PTQ_TIME_MAX_CYC    `PTQ_FLOOR_CYC(`PTQ_TIME_MAX_PS)
`define PTQ_WMIN_MIN_CYC    `PTQ_CEIL_CYC(`PTQ_WMIN_MIN_PS)
`define PTQ_WMIN_MAX_CYC    `PTQ_FLOOR_CYC(`PTQ_WMIN_MAX_PS)
`define PTQ_WMAX_MIN_CYC    `PTQ_CEIL_CYC(`PTQ_WMAX_MIN_PS)
`define PTQ_WMAX_MAX_CYC    `PTQ_FLOOR_CYC(`PTQ_WMAX_MAX_PS)

// ----------------------------------------------------------------
// channel counts and sample width
// ----------------------------------------------------------------
`define PTQ_N_ANA           4
`define PTQ_N_DIG           16
`define PTQ_SAMPLE_W        12

`endif

// ==== logic/ptq_pkg.sv ====
`default_nettype none
`include "ptq_defines.svh"
package ptq_pkg;

    typedef enum logic [4:0] {
        COND_ENTERED       = 5'h01,
        COND_EXITED        = 5'h02,
        COND_LONGER_THAN   = 5'h04,
        COND_SHORTER_THAN  = 5'h08,
        COND_WINDOW        = 5'h10
    } ptq_cond_t;

    typedef enum logic [2:0] {
        CRIT_HIGH           = 3'h0,
        CRIT_LOW            = 3'h1,
        CRIT_IGNORE_CHANNEL = 3'h2,
        CRIT_RISE           = 3'h3,
        CRIT_FALL           = 3'h4
    } ptq_crit_t;

    typedef enum logic [2:0] {
        ST_OFF   = 3'h1,
        ST_ARMED = 3'h2,
        ST_HOLD  = 3'h4
    } ptq_state_t;

    typedef logic [`PTQ_DUR_W-1:0] ptq_dur_t;

    typedef struct packed {
        ptq_cond_t cond;
        logic      fire_on_pattern_end;
        ptq_dur_t  cond_time;
        ptq_dur_t  window_min_time;
        ptq_dur_t  window_max_time;
        ptq_dur_t  retrigger_delay;
    } ptq_cfg_t;

endpackage
`default_nettype wire

// ==== logic/ptq_chan_cmp.sv ====
`default_nettype none
module ptq_chan_cmp #(
    parameter int W = 12
) (
    // clock and reset
    input  wire logic         ref_clk,
    input  wire logic         reset,
    // sample and level settings
    input  wire logic [W-1:0] sample,
    input  wire logic [W-1:0] threshold,
    input  wire logic [W-1:0] noise_reject,
    // result
    output logic              level_r,
    output logic              level_prev_r
);

    // ----------------------------------------------------------------
    // compare with noise_reject band; inside the band the level holds
    // ----------------------------------------------------------------
    wire logic [W:0] s_ext   = {1'b0, sample};
    wire logic [W:0] t_ext   = {1'b0, threshold};
    wire logic [W:0] b_ext   = {1'b0, noise_reject};
    wire logic       is_high = s_ext > (t_ext + b_ext); // R01 R13
    wire logic       is_low  = (s_ext + b_ext) < t_ext; // R01 R13

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            level_r      <= 1'b0;
            level_prev_r <= 1'b0;
        end else begin
            level_prev_r <= level_r;
            if (is_high) begin
                level_r <= 1'b1;
            end else if (is_low) begin
                level_r <= 1'b0;
            end
        end
    end

endmodule
`default_nettype wire

// ==== logic/ptq_top.sv ====
`default_nettype none
`include "ptq_defines.svh"
module ptq_top
    import ptq_pkg::*;
#(
    parameter int N_ANA    = `PTQ_N_ANA,
    parameter int N_DIG    = `PTQ_N_DIG,
    parameter int SAMPLE_W = `PTQ_SAMPLE_W
) (
    // clock and reset
    input  wire logic                       ref_clk,
    input  wire logic                       reset,
    // mode selection
    input  wire logic                       adv_mode_sel,
    input  wire logic                       pattern_submode_sel,
    // configuration
    input  wire ptq_cfg_t                   cfg,
    input  wire ptq_crit_t [N_ANA-1:0]      ana_crit,
    input  wire ptq_crit_t [N_DIG-1:0]      dig_crit,
    input  wire logic [N_DIG-1:0]           dig_fitted,
    // analog samples and thresholds
    input  wire logic [N_ANA-1:0][SAMPLE_W-1:0] ana_sample,
    input  wire logic [N_ANA-1:0][SAMPLE_W-1:0] ana_threshold,
    input  wire logic [SAMPLE_W-1:0]        noise_reject,
    // digital pins
    input  wire logic [N_DIG-1:0]           dig_pin,
    // trigger and status
    output logic                            trig_r,
    output logic                            pattern_r,
    output logic                            active_r,
    // read back
    output ptq_cfg_t                        cfg_rb_r,
    output ptq_crit_t [N_ANA-1:0]           ana_crit_rb_r,
    output ptq_crit_t [N_DIG-1:0]           dig_crit_rb_r
);

    // ----------------------------------------------------------------
    // elaboration checks
    // ----------------------------------------------------------------
    if (N_ANA != 2 && N_ANA != 4) begin : g_bad_ana
        $error("N_ANA must be 2 or 4");
    end
    if (N_DIG < 0 || N_DIG > 16) begin : g_bad_dig
        $error("N_DIG must be 0 to 16");
    end
    if (SAMPLE_W < 2) begin : g_bad_width
        $error("SAMPLE_W too small");
    end

    localparam int NCH = N_ANA + N_DIG;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic ptq_dur_t clamp(input ptq_dur_t v, input logic [63:0] lo, input logic [63:0] hi);
        ptq_dur_t r;
        r = v;
        if ({34'h0, v} < lo) begin
            r = lo[`PTQ_DUR_W-1:0];
        end else if ({34'h0, v} > hi) begin
            r = hi[`PTQ_DUR_W-1:0];
        end
        return r;
    endfunction

    function automatic logic meets(input ptq_crit_t c, input logic lvl, input logic prev);
        logic m;
        m = 1'b1;
        case (c)
            CRIT_HIGH:           m = lvl;
            CRIT_LOW:            m = ~lvl;
            CRIT_IGNORE_CHANNEL: m = 1'b1;
            CRIT_RISE:           m = lvl & ~prev;
            CRIT_FALL:           m = ~lvl & prev;
            default:             m = 1'b1;
        endcase
        return m;
    endfunction

    // ----------------------------------------------------------------
    // per-channel levels
    // ----------------------------------------------------------------
    logic [NCH-1:0] lvl;
    logic [NCH-1:0] lvl_prev;
    logic [NCH-1:0] meet;
    logic [NCH-1:0] part;

    genvar gi;
    generate
        for (gi = 0; gi < N_ANA; gi++) begin : g_ana
            ptq_chan_cmp #(.W(SAMPLE_W)) u_cmp (
                .ref_clk      (ref_clk),
                .reset        (reset),
                .sample       (ana_sample[gi]),
                .threshold    (ana_threshold[gi]), // R15
                .noise_reject (noise_reject),
                .level_r      (lvl[gi]),
                .level_prev_r (lvl_prev[gi])
            );
            assign meet[gi] = meets(ana_crit[gi], lvl[gi], lvl_prev[gi]); // R02
            assign part[gi] = ana_crit[gi] != CRIT_IGNORE_CHANNEL; // R02 R11
        end
        for (gi = 0; gi < N_DIG; gi++) begin : g_dig
            logic s1_r;
            logic s2_r;
            logic p_r;
            always_ff @(posedge ref_clk) begin
                if (reset) begin
                    s1_r <= 1'b0;
                    s2_r <= 1'b0;
                    p_r  <= 1'b0;
                end else begin
                    s1_r <= dig_pin[gi];
                    s2_r <= s1_r;
                    p_r  <= s2_r;
                end
            end
            assign lvl[N_ANA+gi]      = s2_r;
            assign lvl_prev[N_ANA+gi] = p_r;
            assign part[N_ANA+gi]     = dig_fitted[gi] & (dig_crit[gi] != CRIT_IGNORE_CHANNEL); // R02 R11
            assign meet[N_ANA+gi]     = ~part[N_ANA+gi] | meets(dig_crit[gi], s2_r, p_r);
        end
    endgenerate

    // ----------------------------------------------------------------
    // pattern, edges and duration
    // ----------------------------------------------------------------
    wire logic     pat_now   = (&meet) & (|part); // R03
    wire logic     pat_start = pat_now & ~pattern_r;
    wire logic     pat_end   = ~pat_now & pattern_r;
    wire logic     enabled   = adv_mode_sel & pattern_submode_sel; // R12
    wire ptq_dur_t dur_max   = {`PTQ_DUR_W{1'b1}};

    wire ptq_dur_t t_eff   = clamp(cfg.cond_time, `PTQ_TIME_MIN_CYC, `PTQ_TIME_MAX_CYC); // R06
    wire ptq_dur_t wmin    = clamp(cfg.window_min_time, `PTQ_WMIN_MIN_CYC, `PTQ_WMIN_MAX_CYC); // R10
    wire ptq_dur_t wmax    = clamp(cfg.window_max_time, `PTQ_WMAX_MIN_CYC, `PTQ_WMAX_MAX_CYC); // R10

    logic     timeout_done_r;
    ptq_dur_t dur_r;
    ptq_dur_t dur_nxt;

    assign dur_nxt = pat_start ? ptq_dur_t'(1) :
                     (pat_now && dur_r != dur_max) ? dur_r + ptq_dur_t'(1) : dur_r; // R16

    // ----------------------------------------------------------------
    // qualifying conditions
    // ----------------------------------------------------------------
    wire logic hit_enter   = pat_start; // R04
    wire logic hit_exit    = pat_end; // R05
    wire logic hit_gt_end  = pat_end & (dur_r > t_eff) & cfg.fire_on_pattern_end; // R06 R07
    wire logic hit_gt_tmo  = pat_now & pattern_r & (dur_r == t_eff) & ~cfg.fire_on_pattern_end
                             & ~timeout_done_r; // R06 R07
    wire logic hit_lt      = pat_end & (dur_r < t_eff); // R08
    wire logic hit_window  = pat_end & (dur_r > wmin) & (dur_r < wmax); // R09

    logic hit;
    always_comb begin
        case (cfg.cond)
            COND_ENTERED:      hit = hit_enter;
            COND_EXITED:       hit = hit_exit;
            COND_LONGER_THAN:  hit = hit_gt_end | hit_gt_tmo;
            COND_SHORTER_THAN: hit = hit_lt;
            COND_WINDOW:       hit = hit_window;
            default:           hit = 1'b0;
        endcase
    end

    // ----------------------------------------------------------------
    // arm, fire and retrigger delay
    // ----------------------------------------------------------------
    ptq_state_t state_r;
    ptq_state_t state_nxt;
    ptq_dur_t   hold_r;

    wire logic fire = (state_r == ST_ARMED) & enabled & hit;

    always_comb begin
        case (state_r)
            ST_OFF:   state_nxt = enabled ? ST_ARMED : ST_OFF; // R12
            ST_ARMED: state_nxt = !enabled ? ST_OFF : (fire && cfg.retrigger_delay != '0) ? ST_HOLD : ST_ARMED;
            ST_HOLD:  state_nxt = !enabled ? ST_OFF : (hold_r <= ptq_dur_t'(1)) ? ST_ARMED : ST_HOLD; // R13
            default:  state_nxt = ST_OFF;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state_r        <= ST_OFF;
            hold_r         <= '0;
            dur_r          <= '0;
            timeout_done_r <= 1'b0;
            pattern_r      <= 1'b0;
            trig_r         <= 1'b0;
            active_r       <= 1'b0;
        end else begin
            state_r        <= state_nxt;
            hold_r         <= fire ? cfg.retrigger_delay : (hold_r != '0) ? hold_r - ptq_dur_t'(1) : hold_r; // R13
            dur_r          <= dur_nxt;
            timeout_done_r <= pat_now & (timeout_done_r | hit_gt_tmo);
            pattern_r      <= pat_now;
            trig_r         <= fire;
            active_r       <= enabled;
        end
    end

    // ----------------------------------------------------------------
    // read back of programmed settings
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            cfg_rb_r      <= '0;
            ana_crit_rb_r <= '0;
            dig_crit_rb_r <= '0;
        end else begin
            cfg_rb_r      <= cfg; // R14
            ana_crit_rb_r <= ana_crit; // R14
            dig_crit_rb_r <= dig_crit; // R14
        end
    end

endmodule
`default_nettype wire

// ==== tb/ptq_top_assertions.sv ====
`default_nettype none
module ptq_top_assertions
    import ptq_pkg::*;
#(
    parameter int N_ANA = 4
) (
    // clock and reset
    input wire logic            ref_clk,
    input wire logic            reset,
    // watched inputs
    input wire logic            adv_mode_sel,
    input wire logic            pattern_submode_sel,
    input wire ptq_cfg_t        cfg,
    input wire ptq_crit_t [N_ANA-1:0] ana_crit,
    // watched outputs
    input wire logic            trig_r,
    input wire logic            pattern_r,
    input wire logic            active_r,
    input wire ptq_cfg_t        cfg_rb_r,
    input wire ptq_crit_t [N_ANA-1:0] ana_crit_rb_r
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------------------------------
    // run length of the pattern and gap since the last trigger
    // ----------------------------------------------------------------
    logic [31:0] run_r;
    logic [31:0] gap_r;
    wire  [31:0] t_w   = 32'(cfg.cond_time);
    wire  [31:0] mn_w  = 32'(cfg.window_min_time);
    wire  [31:0] mx_w  = 32'(cfg.window_max_time);
    wire         lng_w = cfg.cond == COND_LONGER_THAN;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            run_r <= '0;
            gap_r <= '1;
        end else begin
            run_r <= pattern_r ? run_r + 32'h1 : '0;
            gap_r <= trig_r ? 32'h1 : gap_r + {31'h0, ~&gap_r};
        end
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);

    chk_trig_when_armed: assert property (trig_r |-> $past(active_r))
        else $error("trigger while not armed");
    chk_active_copy: assert property (!$past(reset)
        |-> active_r == ($past(adv_mode_sel) && $past(pattern_submode_sel)))
        else $error("active flag wrong");
    chk_entered_edge: assert property (trig_r && cfg.cond == COND_ENTERED |-> $rose(pattern_r))
        else $error("entered trigger off edge");
    chk_exited_edge: assert property (trig_r && cfg.cond == COND_EXITED |-> $fell(pattern_r))
        else $error("exited trigger off edge");
    chk_longer_end: assert property (trig_r && lng_w && cfg.fire_on_pattern_end
        |-> $fell(pattern_r) && run_r > t_w)
        else $error("longer-than end trigger wrong");
    chk_longer_timeout: assert property (trig_r && lng_w && !cfg.fire_on_pattern_end
        |-> pattern_r && run_r <= t_w && run_r + 32'h1 >= t_w)
        else $error("longer-than timeout trigger wrong");
    chk_shorter_end: assert property (trig_r && cfg.cond == COND_SHORTER_THAN
        |-> $fell(pattern_r) && run_r < t_w)
        else $error("shorter-than trigger wrong");
    chk_window_end: assert property (trig_r && cfg.cond == COND_WINDOW
        |-> $fell(pattern_r) && run_r > mn_w && run_r < mx_w)
        else $error("window trigger wrong");
    chk_retrigger_delay_gap: assert property (trig_r |-> gap_r > 32'(cfg.retrigger_delay))
        else $error("trigger inside retrigger_delay");
    chk_cfg_readback: assert property (!$past(reset)
        |-> cfg_rb_r == $past(cfg) && ana_crit_rb_r == $past(ana_crit))
        else $error("read back differs");
endmodule
`default_nettype wire

// ==== tb/ptq_probe_model.sv ====
`default_nettype none
module ptq_probe_model (
    // clock
    input  wire logic        ref_clk,
    // wanted levels
    input  wire logic        ch0_hi,
    input  wire logic        dig0_hi,
    input  wire logic [11:0] thr,
    // probe lines
    output logic [3:0][11:0] ana_sample,
    output logic [15:0]      dig_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------------------------------
    // analog line 3 and digital lines 1..15 toggle; ignored analog line 2 holds high
    // ----------------------------------------------------------------
    logic noise_r = 1'b0;
    always @(negedge ref_clk) begin
        noise_r <= ~noise_r;
    end
    assign ana_sample[0] = ch0_hi ? thr + 12'h100 : thr - 12'h100;
    assign ana_sample[1] = thr - 12'h100;
    assign ana_sample[2] = thr + 12'h100;
    assign ana_sample[3] = noise_r ? thr + 12'h100 : thr - 12'h100;
    assign dig_pin       = {{15{noise_r}}, dig0_hi};
endmodule
`default_nettype wire

// ==== tb/ptq_top_bench.sv ====
`default_nettype none
module ptq_top_bench
    import ptq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic adv_mode_sel = 1'b0;
    logic pattern_submode_sel = 1'b0;
    ptq_cfg_t cfg = '0;
    ptq_crit_t [3:0] ana_crit;
    ptq_crit_t [15:0] dig_crit;
    logic [3:0][11:0] ana_sample;
    logic [15:0] dig_pin;
    logic ch0_hi = 1'b0;
    logic dig0_hi = 1'b1;
    logic trig_r, pattern_r, active_r;
    ptq_cfg_t cfg_rb_r;
    ptq_crit_t [3:0] ana_crit_rb_r;
    ptq_crit_t [15:0] dig_crit_rb_r;
    int n_errors = 0;
    int total_checks = 0;
    int n_trig = 0;
    int cycles = 0;

    always #5 ref_clk = ~ref_clk;

    ptq_probe_model i_probe (.ref_clk(ref_clk), .ch0_hi(ch0_hi), .dig0_hi(dig0_hi), .thr(12'h800),
                             .ana_sample(ana_sample), .dig_pin(dig_pin));
    ptq_top i_dut (.ref_clk(ref_clk), .reset(reset), .adv_mode_sel(adv_mode_sel),
                   .pattern_submode_sel(pattern_submode_sel), .cfg(cfg), .ana_crit(ana_crit),
                   .dig_crit(dig_crit), .dig_fitted(16'h0001), .ana_sample(ana_sample),
                   .ana_threshold({4{12'h800}}), .noise_reject(12'h010), .dig_pin(dig_pin),
                   .trig_r(trig_r), .pattern_r(pattern_r), .active_r(active_r), .cfg_rb_r(cfg_rb_r),
                   .ana_crit_rb_r(ana_crit_rb_r), .dig_crit_rb_r(dig_crit_rb_r));

    // ----------------------------------------------------------------
    // trigger counter, hang guard, closing report
    // ----------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (trig_r === 1'b1) n_trig++;
        cycles++;
        if (cycles == 3000) begin
            n_errors++;
            end_sim();
        end
    end

    task automatic end_sim();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic cmp_vec(input string nm, input logic [127:0] exp, input logic [127:0] got);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %0h seen %0h", nm, exp, got);
        end
    endtask

    // set up one condition, send np pulses of len cycles, count triggers
    task automatic run_case(input ptq_cond_t c, input logic fe, input int t, mn, mx, hd, input logic en,
                            input ptq_crit_t cr, input logic dh, input int len, np, exp);
        @(negedge ref_clk);
        adv_mode_sel = 1'b0;
        pattern_submode_sel = 1'b0;
        @(negedge ref_clk);
        cfg = '{c, fe, ptq_dur_t'(t), ptq_dur_t'(mn), ptq_dur_t'(mx), ptq_dur_t'(hd)};
        ana_crit[0] = cr;
        dig0_hi = dh;
        adv_mode_sel = en;
        pattern_submode_sel = en;
        repeat (6) @(negedge ref_clk);
        cmp_vec("cfg_rb", 128'(cfg), 128'(cfg_rb_r));
        cmp_vec("ana_crit_rb", 128'(ana_crit), 128'(ana_crit_rb_r));
        cmp_vec("dig_crit_rb", 128'(dig_crit), 128'(dig_crit_rb_r));
        cmp_vec("active", 128'(en), 128'(active_r));
        n_trig = 0;
        repeat (np) begin
            ch0_hi = 1'b1;
            repeat (len) @(negedge ref_clk);
            ch0_hi = 1'b0;
            repeat (3) @(negedge ref_clk);
        end
        repeat (12) @(negedge ref_clk);
        cmp_vec("pattern_idle", 128'(0), 128'(pattern_r));
        cmp_vec("trig_count", 128'(exp), 128'(n_trig));
    endtask

    initial begin
        for (int i = 0; i < 16; i++) dig_crit[i] = CRIT_IGNORE_CHANNEL;
        dig_crit[0] = CRIT_HIGH;
        dig_crit[1] = CRIT_HIGH;
        ana_crit[0] = CRIT_HIGH;
        ana_crit[1] = CRIT_LOW;
        ana_crit[2] = CRIT_IGNORE_CHANNEL;
        ana_crit[3] = CRIT_IGNORE_CHANNEL;
        repeat (12) @(negedge ref_clk);
        reset = 1'b0;
        run_case(COND_ENTERED, 0, 0, 0, 0, 0, 1, CRIT_HIGH, 1, 5, 1, 1);
        run_case(COND_ENTERED, 0, 0, 0, 0, 0, 0, CRIT_HIGH, 1, 5, 1, 0);
        run_case(COND_ENTERED, 0, 0, 0, 0, 0, 1, CRIT_HIGH, 0, 5, 1, 0);
        run_case(COND_ENTERED, 0, 0, 0, 0, 0, 1, CRIT_RISE, 1, 5, 1, 1);
        run_case(COND_ENTERED, 0, 0, 0, 0, 0, 1, CRIT_FALL, 1, 5, 1, 1);
        run_case(COND_EXITED, 0, 0, 0, 0, 0, 1, CRIT_HIGH, 1, 5, 1, 1);
        run_case(COND_LONGER_THAN, 1, 6, 0, 0, 0, 1, CRIT_HIGH, 1, 6, 1, 0);
        run_case(COND_LONGER_THAN, 1, 6, 0, 0, 0, 1, CRIT_HIGH, 1, 7, 1, 1);
        run_case(COND_LONGER_THAN, 0, 6, 0, 0, 0, 1, CRIT_HIGH, 1, 9, 1, 1);
        run_case(COND_LONGER_THAN, 0, 6, 0, 0, 0, 1, CRIT_HIGH, 1, 5, 1, 0);
        run_case(COND_SHORTER_THAN, 0, 6, 0, 0, 0, 1, CRIT_HIGH, 1, 5, 1, 1);
        run_case(COND_SHORTER_THAN, 0, 6, 0, 0, 0, 1, CRIT_HIGH, 1, 6, 1, 0);
        run_case(COND_WINDOW, 0, 0, 4, 8, 0, 1, CRIT_HIGH, 1, 5, 1, 1);
        run_case(COND_WINDOW, 0, 0, 4, 8, 0, 1, CRIT_HIGH, 1, 4, 1, 0);
        run_case(COND_WINDOW, 0, 0, 4, 8, 0, 1, CRIT_HIGH, 1, 8, 1, 0);
        run_case(COND_ENTERED, 0, 0, 0, 0, 5, 1, CRIT_HIGH, 1, 3, 2, 2);
        run_case(COND_ENTERED, 0, 0, 0, 0, 6, 1, CRIT_HIGH, 1, 3, 2, 1);
        end_sim();
    end
endmodule

bind ptq_top ptq_top_assertions #(.N_ANA(N_ANA)) i_chk (.ref_clk(ref_clk), .reset(reset),
    .adv_mode_sel(adv_mode_sel), .pattern_submode_sel(pattern_submode_sel), .cfg(cfg),
    .ana_crit(ana_crit), .trig_r(trig_r), .pattern_r(pattern_r), .active_r(active_r),
    .cfg_rb_r(cfg_rb_r), .ana_crit_rb_r(ana_crit_rb_r));
`default_nettype wire
